// [src/gdfp_pkg.sv]
// Shared constants, types and helpers of the gate-driver fault block.
// Assumes a single 250 MHz clock domain.
`default_nettype none
package gdfp_pkg;
  localparam int CLK_NS         = 4;
  localparam int DESAT_FILT_NS  = 1000;
  localparam int UV_FILT_NS     = 700;
  localparam int UV_DRIVE_NS    = 8000;
  localparam int DESAT_FILT_CYC = (DESAT_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int UV_FILT_CYC    = (UV_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int UV_DRIVE_CYC   = (UV_DRIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W          = 12;
  localparam int TW             = 8;
  localparam logic [7:0] ADDR_STAT  = 8'h00;
  localparam logic [7:0] ADDR_MASK  = 8'h04;
  localparam logic [7:0] ADDR_MODE  = 8'h08;
  localparam logic [7:0] ADDR_DEAD  = 8'h0c;
  localparam logic [7:0] ADDR_BLANK = 8'h10;
  localparam logic [7:0] ADDR_CMD   = 8'h14;
  localparam logic [7:0] ADDR_PHASE = 8'h18;
  localparam int ST_OC    = 0;
  localparam int ST_DESAT = 1;
  localparam int ST_UV    = 2;
  localparam int ST_PHASE = 4;
  localparam int MD_DESAT_KEEP = 0;
  localparam int MD_PHASE_KEEP = 1;
  localparam logic [3:0] OP_IRQ_MASK_CMD_A = 4'h2;
  localparam logic [3:0] OP_MASK1 = 4'h3;
  localparam logic [2:0] OP_MODE  = 3'h2;
  localparam logic [3:0] OP_CLR0  = 4'h6;
  localparam logic [3:0] OP_CLR1  = 4'h7;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [1:0] MODE_RST  = 2'h0;
  localparam logic [7:0] DEAD_RST  = 8'h0c;
  localparam logic [7:0] BLANK_RST = 8'h40;

  typedef enum logic [2:0] {
    UV_OK    = 3'b001,
    UV_DRIVE = 3'b010,
    UV_HOLD  = 3'b100
  } gdfp_uv_e;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic hs_err;
    logic ls_err;
    logic desat;
    logic armed;
  } gdfp_ph_s;

  // Set beats clear so no event is lost
  function automatic logic [7:0] gdfp_latch(input logic [7:0] cur,
                                            input logic [7:0] set,
                                            input logic [7:0] clr);
    return (cur & ~clr) | set;
  endfunction
endpackage
`default_nettype wire

// [src/gdfp_filt.sv]
// Persistence filter: output rises after input held N cycles.
// Assumes input already synchronous to pclk.
`default_nettype none
module gdfp_filt import gdfp_pkg::*; #(
  parameter int N = 4
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in and filtered level out
  input  wire logic din,
  output var  logic dout
);
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      dout <= 1'b0;
    end else if (!din) begin
      // Drop restarts the timer
      cnt  <= '0;
      dout <= 1'b0;
    end else if (cnt == CNT_W'(N - 1)) begin
      dout <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [src/gdfp_phase.sv]
// One phase: edge-driven command, deadtime, blanking, error checks.
// Assumes comparator levels are synchronous to pclk.
`default_nettype none
module gdfp_phase import gdfp_pkg::*; (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Commands and settings
  input  wire logic          up_cmd,
  input  wire logic          lo_cmd,
  input  wire logic [TW-1:0] deadtime,
  input  wire logic [TW-1:0] blank,
  input  wire logic          force_off,
  // Comparators
  input  wire logic          node_high,
  input  wire logic          desat_cmp,
  // State out
  output var  gdfp_ph_s      ph
);
  logic          up_d;
  logic          lo_d;
  logic [1:0]    want;
  logic [TW-1:0] dt;
  logic [TW-1:0] bl;
  logic          chk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_d <= 1'b0;
      lo_d <= 1'b0;
    end else begin
      up_d <= up_cmd;
      lo_d <= lo_cmd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      want <= 2'h0;
      dt <= '0;
      bl <= '0;
      chk <= 1'b0;
      ph <= '0;
    end else begin
      ph.hs_err <= 1'b0;
      ph.ls_err <= 1'b0;
      if (force_off) begin
        want <= 2'h0;
        ph.hs_on <= 1'b0;
        ph.ls_on <= 1'b0;
        ph.armed <= 1'b0;
        ph.desat <= 1'b0;
        chk <= 1'b0;
      end else begin
        if (lo_d && !lo_cmd) ph.armed <= 1'b1;
        if (up_cmd && !up_d) begin
          want <= 2'h1;
          if (ph.ls_on) dt <= deadtime;
          ph.ls_on <= 1'b0;
        end else if (lo_cmd && (!lo_d || want == 2'h0)) begin
          want <= 2'h2;
          if (ph.hs_on) dt <= deadtime;
          ph.hs_on <= 1'b0;
          ph.desat <= 1'b0;
        end else if ((want == 2'h1 && !up_cmd) ||
                     (want == 2'h2 && !lo_cmd)) begin
          want <= 2'h0;
          dt <= deadtime;
          ph.hs_on <= 1'b0;
          ph.ls_on <= 1'b0;
          ph.desat <= 1'b0;
          chk <= 1'b0;
        end else if (dt != '0) begin
          dt <= dt - 1'b1;
        end else if (want == 2'h1 && !ph.hs_on && ph.armed) begin
          ph.hs_on <= 1'b1;
          bl <= blank;
          chk <= 1'b1;
        end else if (want == 2'h2 && !ph.ls_on) begin
          ph.ls_on <= 1'b1;
          bl <= blank;
          chk <= 1'b1;
        end else if (bl != '0) begin
          bl <= bl - 1'b1;
        end else if (chk) begin
          chk <= 1'b0;
          ph.hs_err <= ph.hs_on && !node_high;
          ph.ls_err <= ph.ls_on && node_high;
        end
        if (ph.hs_on && !chk && bl == '0) ph.desat <= desat_cmp;
      end
    end
  end

  a_hs_after_dead: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ph.hs_on) |-> $past(dt) == '0 && !$past(ph.ls_on))
    else $error("upper switch on inside deadtime");
endmodule
`default_nettype wire

// [src/gdfp_top.sv]
// Fault protection core of a three-phase pre-driver with APB registers.
// Assumes synchronous comparator inputs and an APB master on pclk.
//
// The placing of the registers and register access over APB are this design's own decisions.
`default_nettype none
// Operation
// - Over-current latches and drives flag output
// - Over-current in status; masked interrupt
// - Interrupt holds until gone and cleared
// - Deadtime from low off, then high on
// - Desat starts if source low after blank
// - Desat registered after 1.0 us persistence
// - Desat switches off all six gates
// - Desat drop resets filter, discards fault
// - Faults readable in status register
// - Commands mask and disable desat/phase shutdown
// - Phase node compared to half supply
// - Upper on, node low: high error
// - Lower on, node high: low error
// - Phase errors ORed per phase, all phases
// - Phase interrupt cleared by second clear
// - Undervoltage: drive off 8 us, hold
// - Undervoltage filtered about 700 ns
// - Recovery: lower follows, upper waits init
// - Upper high impedance until lower turns off
// - Hold-off on reset, low supplies
// - Charge pump on below, off above hysteresis
// - Any fault needs lower-upper reinitialization (over-current does not force the gates off or disarm here)
// - Clear 0110 clears flags per bit
// - Interrupt stays if other faults remain
module gdfp_top import gdfp_pkg::*; #(
  parameter int DESAT_N = DESAT_FILT_CYC,
  parameter int UVF_N   = UV_FILT_CYC,
  parameter int UVD_N   = UV_DRIVE_CYC
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Switch commands and enable
  input  wire logic [2:0]  upper_switch_command,
  input  wire logic [2:0]  lower_switch_command,
  input  wire logic        drive_enable,
  // Comparator and supply levels
  input  wire logic        sense_amp_over,
  input  wire logic [2:0]  phase_source_node,
  input  wire logic [2:0]  desat_detect,
  input  wire logic        gate_drive_supply_uv,
  input  wire logic        gate_supply_disable,
  input  wire logic        vdd_low,
  input  wire logic        pump_below_on,
  input  wire logic        pump_above_off,
  // Gate drive and flags
  output var  logic [2:0]  upper_gate_output,
  output var  logic [2:0]  upper_gate_oe,
  output var  logic [2:0]  lower_gate_output,
  output var  logic        hold_off_en,
  output var  logic        overcurrent_flag_out,
  output var  logic        fault_irq,
  output var  logic        charge_pump_en
);
  ////////////////////////////////////////////////////////////////////////
  gdfp_ph_s     ph [3];
  logic [2:0]   desat_reg;
  logic         uv_q;
  gdfp_uv_e     uv_st;
  logic [CNT_W-1:0] uv_cnt;
  logic [7:0]   status;
  logic [7:0]   mask;
  logic [1:0]   mode;
  logic [TW-1:0] deadtime;
  logic [TW-1:0] blank;
  logic         sd;
  logic         force_off;
  logic         hold;
  logic [7:0]   set_v;
  logic [7:0]   clr_v;
  logic [7:0]   next_status;
  logic [7:0]   next_mask;
  logic         wr;
  logic         acc;
  logic [7:0]   cmd;
  logic [2:0]   perr;
  logic         trig;

  ////////////////////////////////////////////////////////////////////////
  // Per-phase sequencing and desat persistence
  for (genvar g = 0; g < 3; g++) begin : g_ph
    gdfp_phase u_ph (
      .pclk      (pclk),
      .presetn   (presetn),
      .up_cmd    (upper_switch_command[g]),
      .lo_cmd    (lower_switch_command[g]),
      .deadtime  (deadtime),
      .blank     (blank),
      .force_off (force_off),
      .node_high (phase_source_node[g]),
      .desat_cmp (desat_detect[g]),
      .ph        (ph[g])
    );
    gdfp_filt #(.N(DESAT_N)) u_dsf (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ph[g].desat),
      .dout    (desat_reg[g])
    );
    assign perr[g] = ph[g].hs_err | ph[g].ls_err;
  end

  // Short glitches on the supply must not trip shutdown
  gdfp_filt #(.N(UVF_N)) u_uvf (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (gate_drive_supply_uv),
    .dout    (uv_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command decode and fault latches
  assign acc = psel && penable && pready;
  assign wr  = acc && pwrite && !pslverr;
  assign cmd = pwdata[7:0];

  always_comb begin
    set_v = '0;
    set_v[ST_OC]    = sense_amp_over;
    set_v[ST_DESAT] = |desat_reg;
    set_v[ST_UV]    = uv_q;
    set_v[ST_PHASE] = |perr;
    clr_v = '0;
    if (wr && paddr == ADDR_CMD && cmd[7:4] == OP_CLR0)
      clr_v[3:0] = cmd[3:0];
    if (wr && paddr == ADDR_CMD && cmd[7:4] == OP_CLR1)
      clr_v[7:4] = cmd[3:0];
    next_status = gdfp_latch(status, set_v, clr_v);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status <= '0;
    else status <= next_status;
  end

  // Mask write reaches the interrupt in the same cycle as the register
  always_comb begin
    next_mask = mask;
    if (wr && paddr == ADDR_MASK) next_mask = pwdata[7:0];
    if (wr && paddr == ADDR_CMD && cmd[7:4] == OP_IRQ_MASK_CMD_A)
      next_mask[3:0] = cmd[3:0];
    if (wr && paddr == ADDR_CMD && cmd[7:4] == OP_MASK1)
      next_mask[7:4] = cmd[3:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask <= MASK_RST;
    else mask <= next_mask;
  end

  // Interrupt tracks unmasked, uncleared faults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fault_irq <= 1'b0;
    else fault_irq <= |(next_status & next_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) overcurrent_flag_out <= 1'b0;
    else overcurrent_flag_out <= sense_amp_over;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RST;
      deadtime <= DEAD_RST;
      blank <= BLANK_RST;
    end else if (wr) begin
      unique case (paddr)
        ADDR_MODE:  mode <= pwdata[1:0];
        ADDR_DEAD:  deadtime <= pwdata[TW-1:0];
        ADDR_BLANK: blank <= pwdata[TW-1:0];
        ADDR_CMD:   if (cmd[7:5] == OP_MODE) mode <= cmd[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protective shutdown, held until its status bits are cleared
  assign trig = (|desat_reg && !mode[MD_DESAT_KEEP]) ||
                (|perr && !mode[MD_PHASE_KEEP]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sd <= 1'b0;
    else sd <= trig ||
               (sd && (next_status[ST_DESAT] || next_status[ST_PHASE]));
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply undervoltage sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_st <= UV_OK;
      uv_cnt <= '0;
    end else begin
      unique case (uv_st)
        UV_OK: if (uv_q) begin
          uv_st <= UV_DRIVE;
          uv_cnt <= '0;
        end
        UV_DRIVE: if (!uv_q) begin
          uv_st <= UV_OK;
        end else if (uv_cnt == CNT_W'(UVD_N - 1)) begin
          uv_st <= UV_HOLD;
        end else begin
          uv_cnt <= uv_cnt + 1'b1;
        end
        UV_HOLD: if (!uv_q) uv_st <= UV_OK;
        default: uv_st <= UV_OK;
      endcase
    end
  end

  // Shutdown, hold, undervoltage and drive-disable paths disarm the upper switches until re-init; over-current does not
  assign hold = vdd_low || gate_supply_disable || uv_st == UV_HOLD;
  assign force_off = sd || hold || uv_st != UV_OK || !drive_enable;

  ////////////////////////////////////////////////////////////////////////
  // Gate outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_gate_output <= '0;
      upper_gate_oe <= '0;
      lower_gate_output <= '0;
      hold_off_en <= 1'b1;
    end else begin
      hold_off_en <= hold;
      for (int i = 0; i < 3; i++) begin
        if (hold) begin
          upper_gate_output[i] <= 1'b0;
          upper_gate_oe[i] <= 1'b0;
          lower_gate_output[i] <= 1'b0;
        end else if (force_off) begin
          upper_gate_output[i] <= 1'b0;
          upper_gate_oe[i] <= 1'b1;
          lower_gate_output[i] <= 1'b0;
        end else begin
          upper_gate_output[i] <= ph[i].hs_on;
          upper_gate_oe[i] <= ph[i].armed;
          lower_gate_output[i] <= ph[i].ls_on;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) charge_pump_en <= 1'b0;
    else if (pump_below_on) charge_pump_en <= 1'b1;
    else if (pump_above_off) charge_pump_en <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // APB: no wait state, answer in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          ADDR_STAT:  prdata <= {24'h0, status};
          ADDR_MASK:  prdata <= {24'h0, mask};
          ADDR_MODE:  prdata <= {30'h0, mode};
          ADDR_DEAD:  prdata <= {24'h0, deadtime};
          ADDR_BLANK: prdata <= {24'h0, blank};
          ADDR_CMD:   prdata <= '0;
          ADDR_PHASE: prdata <= {24'h0, uv_st, sd, phase_source_node,
                                 charge_pump_en};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_desat_cause;
    desat_reg[0] && !mode[MD_DESAT_KEEP];
  endsequence

  a_oc_latch: assert property (@(posedge pclk) disable iff (!presetn)
    sense_amp_over |=> status[ST_OC] && overcurrent_flag_out)
    else $error("over-current not latched");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    fault_irq == |(status & mask))
    else $error("interrupt disagrees with masked status");

  a_irq_stays: assert property (@(posedge pclk) disable iff (!presetn)
    (|(status & mask & ~clr_v)) |=> fault_irq)
    else $error("interrupt dropped with faults pending");

  a_oc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clr_v[ST_OC] && !sense_amp_over |=> !status[ST_OC])
    else $error("clear command ignored");

  a_desat_drop: assert property (@(posedge pclk) disable iff (!presetn)
    !ph[0].desat |=> !desat_reg[0])
    else $error("desat registered without persistence");

  a_desat_off: assert property (@(posedge pclk) disable iff (!presetn)
    s_desat_cause |-> ##2 upper_gate_output == '0 && lower_gate_output == '0)
    else $error("gates not off after desat");

  a_uv_drive: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(uv_st == UV_DRIVE) |-> (uv_st == UV_DRIVE)[*8])
    else $error("active drive-off too short");

  a_hold_path: assert property (@(posedge pclk) disable iff (!presetn)
    hold |=> hold_off_en && upper_gate_oe == '0)
    else $error("hold-off not applied");

  a_pump_on: assert property (@(posedge pclk) disable iff (!presetn)
    pump_below_on |=> charge_pump_en)
    else $error("charge pump not enabled");

  a_pump_off: assert property (@(posedge pclk) disable iff (!presetn)
    pump_above_off && !pump_below_on |=> !charge_pump_en)
    else $error("charge pump not disabled");

  a_hs_arm: assert property (@(posedge pclk) disable iff (!presetn)
    !ph[0].armed && !force_off |=> !upper_gate_oe[0])
    else $error("upper gate driven before init");
endmodule
`default_nettype wire

// [testbench/gdfp_host.sv]
// Host model: APB master that sets masks and clears fault latches.
// Assumes one pclk domain; only the bench watchdog ends a wait.
`default_nettype none
module gdfp_host import gdfp_pkg::*; (
  // Clock
  input  wire logic        pclk,
  // APB master side
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////
  // Entered just after a rising edge; returns on one
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep the old value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic mask(input logic hi, input logic [3:0] b);
    wr(ADDR_CMD, {24'h0, hi ? OP_MASK1 : OP_IRQ_MASK_CMD_A, b});
  endtask

  task automatic clear(input logic hi, input logic [3:0] b);
    wr(ADDR_CMD, {24'h0, hi ? OP_CLR1 : OP_CLR0, b});
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench of the fault block with a host model on APB.
// Assumes short filter counts; comparator inputs driven directly.
`default_nettype none
module tb_top import gdfp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEAD = 6;
  localparam int BLANK = 4;
  localparam int DN = 4;
  localparam int UN = 3;
  localparam int UD = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  upper_switch_command, lower_switch_command;
  logic [2:0]  phase_source_node, desat_detect;
  logic [2:0]  upper_gate_output, upper_gate_oe, lower_gate_output;
  logic        drive_enable, sense_amp_over, gate_drive_supply_uv;
  logic        gate_supply_disable, vdd_low, pump_below_on;
  logic        pump_above_off, hold_off_en, overcurrent_flag_out;
  logic        fault_irq, charge_pump_en;
  int          n_fail = 0;
  int          n_tests = 0;

  gdfp_top #(.DESAT_N(DN), .UVF_N(UN), .UVD_N(UD)) gdfp_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .upper_switch_command,
    .lower_switch_command, .drive_enable, .sense_amp_over,
    .phase_source_node, .desat_detect, .gate_drive_supply_uv,
    .gate_supply_disable, .vdd_low, .pump_below_on, .pump_above_off,
    .upper_gate_output, .upper_gate_oe, .lower_gate_output,
    .hold_off_en, .overcurrent_flag_out, .fault_irq, .charge_pump_en);

  gdfp_host gdfp_host_i (.pclk, .psel, .penable, .pwrite, .paddr,
                         .pwdata, .prdata, .pready, .pslverr);

  always #2 pclk = ~pclk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    gdfp_host_i.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
  endtask

  task automatic wait_up(output int n);
    n = 0;
    while (upper_gate_output[0] !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd("mask", ADDR_MASK, {24'h0, MASK_RST});
    rd("mode", ADDR_MODE, {30'h0, MODE_RST});
    rd("dead", ADDR_DEAD, {24'h0, DEAD_RST});
    rd("blank", ADDR_BLANK, {24'h0, BLANK_RST});
    rd("status", ADDR_STAT, 32'h0);
    rd("cmd", ADDR_CMD, 32'h0);
    rd("phase", ADDR_PHASE, {24'h0, UV_OK, 5'h00});
    gdfp_host_i.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    gdfp_host_i.wr(ADDR_DEAD, DEAD);
    gdfp_host_i.wr(ADDR_BLANK, BLANK);
    rd("dead", ADDR_DEAD, DEAD);
    $display("register test done");
  endtask

  task automatic t_oc();
    sense_amp_over <= 1'b1;
    @(posedge pclk);
    chk("oc flag early", 0, overcurrent_flag_out);
    @(posedge pclk);
    chk("oc flag", 1, overcurrent_flag_out);
    rd("status oc", ADDR_STAT, 32'h1);
    chk("irq unmasked", 0, fault_irq);
    gdfp_host_i.mask(1'b0, 4'h1);
    tick(3);
    chk("irq oc", 1, fault_irq);
    gdfp_host_i.clear(1'b0, 4'h1);
    rd("status held", ADDR_STAT, 32'h1);
    sense_amp_over <= 1'b0;
    tick(4);
    chk("irq held", 1, fault_irq);
    gdfp_host_i.clear(1'b0, 4'h1);
    tick(3);
    rd("status cleared", ADDR_STAT, 32'h0);
    chk("irq cleared", 0, fault_irq);
    $display("over-current test done");
  endtask

  task automatic t_desat();
    int n;
    drive_enable <= 1'b1;
    lower_switch_command[0] <= 1'b1;
    tick(10);
    lower_switch_command[0] <= 1'b0;
    tick(DEAD + 4);
    lower_switch_command[0] <= 1'b1;
    tick(DEAD + BLANK + 6);
    lower_switch_command[0] <= 1'b0;
    upper_switch_command[0] <= 1'b1;
    phase_source_node[0] <= 1'b1;
    wait_up(n);
    chk("deadtime", 1, n > DEAD && n < 50);
    chk("lower off", 0, lower_gate_output[0]);
    tick(BLANK + 6);
    desat_detect[0] <= 1'b1;
    tick(DN - 1);
    desat_detect[0] <= 1'b0;
    tick(8);
    rd("status glitch", ADDR_STAT, 32'h0);
    chk("upper kept", 1, upper_gate_output[0]);
    desat_detect[0] <= 1'b1;
    tick(DN + 8);
    chk("gates off", 0, {upper_gate_output, lower_gate_output});
    rd("status desat", ADDR_STAT, 32'h2);
    gdfp_host_i.mask(1'b0, 4'h2);
    tick(3);
    chk("irq desat", 1, fault_irq);
    desat_detect[0] <= 1'b0;
    gdfp_host_i.clear(1'b0, 4'h2);
    tick(4);
    chk("irq desat clr", 0, fault_irq);
    chk("no restart", 0, upper_gate_output[0]);
    upper_switch_command[0] <= 1'b0;
    phase_source_node[0] <= 1'b0;
    lower_switch_command[0] <= 1'b1;
    tick(DEAD + 4);
    lower_switch_command[0] <= 1'b0;
    tick(DEAD + 4);
    upper_switch_command[0] <= 1'b1;
    phase_source_node[0] <= 1'b1;
    wait_up(n);
    chk("reinit", 1, n < 50);
    upper_switch_command[0] <= 1'b0;
    phase_source_node[0] <= 1'b0;
    tick(DEAD + 4);
    $display("desaturation test done");
  endtask

  task automatic t_phase();
    phase_source_node[1] <= 1'b1;
    lower_switch_command[1] <= 1'b1;
    tick(DEAD + BLANK + 8);
    rd("status phase", ADDR_STAT, 32'h10);
    chk("phase shutdown", 0, lower_gate_output);
    gdfp_host_i.mask(1'b1, 4'h1);
    tick(3);
    chk("irq phase", 1, fault_irq);
    phase_source_node[1] <= 1'b0;
    lower_switch_command[1] <= 1'b0;
    tick(4);
    gdfp_host_i.clear(1'b1, 4'h1);
    tick(4);
    rd("status phase clr", ADDR_STAT, 32'h0);
    chk("irq phase clr", 0, fault_irq);
    gdfp_host_i.wr(ADDR_CMD, {24'h0, OP_MODE, 5'h02});
    {phase_source_node[1], lower_switch_command[1]} <= 2'b11;
    tick(DEAD + BLANK + 8);
    chk("phase keep", 1, lower_gate_output[1]);
    rd("status keep", ADDR_STAT, 32'h10);
    {phase_source_node[1], lower_switch_command[1]} <= 2'b00;
    gdfp_host_i.clear(1'b1, 4'h1);
    gdfp_host_i.wr(ADDR_MODE, {30'h0, MODE_RST});
    rd("status keep clr", ADDR_STAT, 32'h0);
    $display("phase test done");
  endtask

  task automatic t_uv();
    int n;
    lower_switch_command[2] <= 1'b1;
    tick(DEAD + 4);
    gate_drive_supply_uv <= 1'b1;
    tick(UN - 1);
    gate_drive_supply_uv <= 1'b0;
    tick(8);
    rd("status uv glitch", ADDR_STAT, 32'h0);
    gate_drive_supply_uv <= 1'b1;
    tick(UN + 4);
    chk("uv strong off", 32'h380, {upper_gate_oe, upper_gate_output,
        lower_gate_output, hold_off_en});
    n = UN + 4;
    while (hold_off_en !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    chk("uv drive span", 1, n >= UN + UD && n < 80);
    rd("status uv", ADDR_STAT, 32'h4);
    gate_drive_supply_uv <= 1'b0;
    tick(DEAD + 4);
    chk("lower follows", 1, lower_gate_output[2]);
    chk("upper hi-z", 0, upper_gate_oe[2]);
    gdfp_host_i.clear(1'b0, 4'h4);
    rd("status uv clr", ADDR_STAT, 32'h0);
    $display("undervoltage test done");
  endtask

  task automatic t_hold_pump();
    for (int i = 0; i < 2; i++) begin
      {vdd_low, gate_supply_disable} <= 2'(1 << i);
      tick(2);
      chk("hold off", 1, hold_off_en);
      chk("hold gates", 0, lower_gate_output);
      {vdd_low, gate_supply_disable} <= 2'b00;
      tick(3);
    end
    pump_below_on <= 1'b1;
    tick(2);
    chk("pump on", 1, charge_pump_en);
    pump_below_on <= 1'b0;
    tick(3);
    chk("pump kept", 1, charge_pump_en);
    pump_above_off <= 1'b1;
    tick(2);
    chk("pump off", 0, charge_pump_en);
    pump_above_off <= 1'b0;
    $display("hold-off and pump test done");
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {upper_switch_command, lower_switch_command, drive_enable,
     sense_amp_over, phase_source_node, desat_detect,
     gate_drive_supply_uv, gate_supply_disable, vdd_low,
     pump_below_on, pump_above_off} = '0;
    tick(10);
    chk("reset hold", 1, hold_off_en);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_oc();
    t_desat();
    t_phase();
    t_uv();
    t_hold_pump();
    test_done();
  end

  // Whole run is well under 2000 cycles
  initial begin
    tick(20000);
    n_fail++;
    $display("watchdog expired");
    test_done();
  end
endmodule
`default_nettype wire
